// >>> design/fas_pkg.sv
// Shared constants and types for the floating add sequencer
package fas_pkg;
	localparam int WORD_W = 48;
	localparam int EXP_W  = 12;
	localparam int STEP_W = 6;
	localparam int EXP_LSB = 36;
	localparam int EXP_MSB = 46;
	localparam int SIGN_BIT = 47;
	localparam int COEF_MSB = 35;
	localparam int NORM_HI = 37;
	localparam int NORM_LO = 36;
	localparam logic [10:0] EXP_BIAS = 11'h400;
	localparam logic [EXP_W-1:0] EXP_MAX = 12'h3FF;
	localparam logic [EXP_W-1:0] EXP_MIN = 12'hC00;
	localparam logic [EXP_W-1:0] SHIFT_LIMIT = 12'h024;
	localparam logic [EXP_W-1:0] CNT_ONE = 12'h001;
	localparam logic [WORD_W-1:0] UNIT_WORD = 48'h0000_0000_0001;
	localparam logic [STEP_W-1:0] ST_00 = 6'h00;
	localparam logic [STEP_W-1:0] ST_01 = 6'h01;
	localparam logic [STEP_W-1:0] ST_02 = 6'h02;
	localparam logic [STEP_W-1:0] ST_03 = 6'h03;
	localparam logic [STEP_W-1:0] ST_05 = 6'h05;
	localparam logic [STEP_W-1:0] ST_06 = 6'h06;
	localparam logic [STEP_W-1:0] ST_07 = 6'h07;
	localparam logic [STEP_W-1:0] ST_08 = 6'h08;
	localparam logic [STEP_W-1:0] ST_09 = 6'h09;
	localparam logic [STEP_W-1:0] ST_11 = 6'h0B;
	localparam logic [STEP_W-1:0] ST_12 = 6'h0C;
	localparam logic [STEP_W-1:0] ST_13 = 6'h0D;
	localparam logic [STEP_W-1:0] ST_14 = 6'h0E;
	localparam logic [STEP_W-1:0] ST_15 = 6'h0F;
	localparam logic [STEP_W-1:0] ST_16 = 6'h10;
	localparam logic [STEP_W-1:0] ST_17 = 6'h11;
	localparam logic [STEP_W-1:0] ST_18 = 6'h12;
	localparam logic [STEP_W-1:0] ST_19 = 6'h13;
	localparam logic [STEP_W-1:0] ST_20 = 6'h14;
	localparam logic [STEP_W-1:0] ST_21 = 6'h15;
	localparam logic [STEP_W-1:0] ST_22 = 6'h16;
	localparam logic [STEP_W-1:0] ST_23 = 6'h17;
	localparam logic [STEP_W-1:0] ST_25 = 6'h19;
	localparam logic [STEP_W-1:0] ST_26 = 6'h1A;
	localparam logic [STEP_W-1:0] ST_28 = 6'h1C;
	localparam logic [STEP_W-1:0] ST_31 = 6'h1F;
	localparam logic [STEP_W-1:0] ST_33 = 6'h21;
	localparam logic [STEP_W-1:0] ST_35 = 6'h23;
	localparam logic [STEP_W-1:0] ST_36 = 6'h24;
	localparam logic [STEP_W-1:0] ST_39 = 6'h27;
	localparam logic [STEP_W-1:0] ST_41 = 6'h29;
	localparam logic [STEP_W-1:0] ST_42 = 6'h2A;
	localparam logic [STEP_W-1:0] ST_43 = 6'h2B;
	localparam logic [STEP_W-1:0] ST_44 = 6'h2C;
	localparam logic [STEP_W-1:0] ST_45 = 6'h2D;
	localparam logic [STEP_W-1:0] ST_46 = 6'h2E;
	localparam logic [STEP_W-1:0] ST_47 = 6'h2F;
	localparam logic [STEP_W-1:0] ST_48 = 6'h30;
	localparam logic [STEP_W-1:0] ST_49 = 6'h31;
	typedef enum logic [1:0] {
		FAS_IDLE,
		FAS_RUN,
		FAS_ALIGN,
		FAS_LNORM
	} fas_mode_t;
endpackage

// >>> design/fas_oc_add.sv
// Ones' complement adder with end-around carry
`timescale 1ns/1ns
module fas_oc_add #(
	parameter int W = 48
) (
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	output logic      [W-1:0] sum
);
	logic [W:0] raw;

	// Carry out of the top folds back into bit zero
	always_comb begin
		raw = {1'b0, a} + {1'b0, b};
		sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
	end
endmodule

// >>> design/fas_step_chain.sv
// Timing chain: step counter that advances, holds or jumps
`timescale 1ns/1ns
module fas_step_chain
	import fas_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              run,
	input  wire logic              jump,
	input  wire logic [STEP_W-1:0] jump_step,
	output logic      [STEP_W-1:0] step
);
	typedef struct packed {
		logic [STEP_W-1:0] step;
	} fas_chain_t;

	fas_chain_t s_q;
	fas_chain_t s_d;

	// Jump beats advance; with neither jump nor run the chain holds
	always_comb begin
		s_d = s_q;
		if (jump) begin
			s_d.step = jump_step;
		end else if (run) begin
			s_d.step = s_q.step + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign step = s_q.step;
endmodule

// >>> design/fas_seq.sv
// Floating add sequencer: align, add, round, normalize, pack
`timescale 1ns/1ns
// What this block does
// - Step 17 records negative addend sign
// - Sub-sequence step 00 equals main step 18
// - Step 18 complements negative addend, sets slave
// - Step 01 copies second rank into first
// - Step 02 unbiased exponent; clear wait storage
// - Step 08 forms difference, keeps function code
// - Step 11 clears accumulator if augend larger
// - Step 15 loads positive shift count
// - Zero-count flop step 16, slaves step 17
// - Step 18 zero count clears those flops
// - Step 20 clears accumulator if count>=36
// - Count<=36 shifts right until count zero
// - Step 21 count above 36 skips shifting
// - Step 22 unlike signs set execute-round
// - Step 25 adds second rank to accumulator
// - Step 26 forces plus/minus one; 31 rounds
// - Bit37 differs bit36: shift right, raise exponent
// - Step 35 zero sum clears left normalize
// - Left normalize resumes at even step 36
// - Step 41 inhibit-add if nonzero; record sign
// - Steps 44-46 exponent, bias, sign restored
// - Steps 47-49 transfer, fault record, clear
module fas_seq
	import fas_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              start,
	input  wire logic [WORD_W-1:0] addend,
	input  wire logic [WORD_W-1:0] augend_char,
	input  wire logic [EXP_W-1:0]  augend_exp_neg,
	input  wire logic              fault_clear,
	output logic      [WORD_W-1:0] acc,
	output logic      [WORD_W-1:0] resid,
	output logic                   busy,
	output logic                   done,
	output logic      [STEP_W-1:0] step_num,
	output logic                   wait_storage,
	output logic                   round_pending,
	output logic                   overflow_fault,
	output logic                   underflow_fault
);
	typedef struct packed {
		fas_mode_t         mode;
		logic [WORD_W-1:0] acc;
		logic [WORD_W-1:0] q;
		logic [WORD_W-1:0] x1;
		logic [WORD_W-1:0] x2;
		logic [EXP_W-1:0]  u1;
		logic [EXP_W-1:0]  u2;
		logic [EXP_W-1:0]  r1;
		logic [EXP_W-1:0]  r2;
		logic              sign_record_flop;
		logic              sign_record_slave_flop;
		logic              wait_storage_flop;
		logic              keep_function_code_flop;
		logic              exp_diff_sign_flop;
		logic              partial_add_exp_flop;
		logic              clear_acc_flop_b;
		logic              clear_acc_flop;
		logic              zero_count_flop;
		logic              zero_count_slave_a;
		logic              zero_count_slave_b;
		logic              partial_add_acc_flop;
		logic              right_shift_enable_a;
		logic              right_shift_enable_b;
		logic              float_shift_exit_flop;
		logic              shift_exit_flop;
		logic              inhibit_acc_copy_flop;
		logic              round_pending_flop;
		logic              force_unit_operand_flop;
		logic              acc_negative_memo_flop;
		logic              left_normalize_flop;
		logic              right_shift_exit_flop;
		logic              inhibit_add_flop;
		logic              result_sign_flop;
		logic              end_around_link_flop;
		logic              underflow_clear_flop;
		logic              overflow_fault_flop;
		logic              underflow_fault_flop;
		logic              ovf_pend;
		logic              unf_pend;
		logic              norm_right_memo;
		logic              done;
	} fas_state_t;

	fas_state_t        s_q;
	fas_state_t        s_d;
	logic [STEP_W-1:0] step;
	logic              jump;
	logic [STEP_W-1:0] jump_step;
	logic [WORD_W-1:0] add_sum;
	logic [EXP_W-1:0]  diff;
	logic [EXP_W-1:0]  exp_fin;

	// One adder serves both the characteristic sum and the round
	fas_oc_add #(.W(WORD_W)) u_add (
		.a   (s_q.acc),
		.b   (s_q.x2),
		.sum (add_sum)
	);

	// Chain holds at 21 or 35 while a shift loop runs
	fas_step_chain u_chain (
		.clk       (clk),
		.rst_b     (rst_b),
		.run       (s_d.mode == FAS_RUN),
		.jump      (jump),
		.jump_step (jump_step),
		.step      (step)
	);

	assign diff = s_q.u2 + s_q.r1;
	assign exp_fin = s_q.u2 + s_q.r1;

	// Whole command schedule; shared steps act in one cycle
	always_comb begin
		s_d = s_q;
		jump = 1'b0;
		jump_step = ST_00;
		s_d.done = 1'b0;
		// Fault flags: a fresh fault beats a clear in the same cycle
		if (fault_clear) begin
			s_d.overflow_fault_flop = 1'b0;
			s_d.underflow_fault_flop = 1'b0;
		end
		unique case (s_q.mode)
		FAS_IDLE: begin
			if (start) begin
				// The start cycle is main step 17
				s_d.mode = FAS_RUN;
				s_d.x1 = addend;
				s_d.acc = augend_char;
				s_d.r1 = augend_exp_neg;
				s_d.wait_storage_flop = 1'b1;
				s_d.sign_record_flop = addend[SIGN_BIT];
				s_d.sign_record_slave_flop = 1'b0;
				jump = 1'b1;
				jump_step = ST_00;
			end
		end
		FAS_ALIGN: begin
			// Shift AQ right one place per cycle, counting down
			if (s_q.r1 == '0) begin
				s_d.right_shift_enable_a = 1'b0;
				s_d.right_shift_enable_b = 1'b0;
				s_d.mode = FAS_RUN;
				jump = 1'b1;
				jump_step = ST_22;
			end else begin
				{s_d.acc, s_d.q} = {s_q.acc[SIGN_BIT], s_q.acc,
					s_q.q[WORD_W-1:1]};
				s_d.r1 = s_q.r1 - CNT_ONE;
			end
		end
		FAS_LNORM: begin
			// Normalized once the top coefficient bit leaves the sign
			if (s_q.acc[COEF_MSB] != s_q.acc[SIGN_BIT]) begin
				s_d.left_normalize_flop = 1'b0;
				s_d.mode = FAS_RUN;
				jump = 1'b1;
				jump_step = ST_36;
			end else begin
				{s_d.acc, s_d.q} = {s_q.acc[WORD_W-2:0], s_q.q,
					s_q.acc[SIGN_BIT]};
				s_d.r1 = s_q.r1 - CNT_ONE;
			end
		end
		FAS_RUN: begin
			unique case (step)
			ST_00: begin
				// Main step 18
				if (s_q.sign_record_flop) begin
					s_d.x2 = ~s_q.x1;
					s_d.sign_record_slave_flop = 1'b1;
				end else begin
					s_d.x2 = s_q.x1;
				end
			end
			ST_01: s_d.x1 = s_q.x2;
			ST_02: begin
				// Top exponent bit flipped removes the bias
				s_d.u2 = {~s_q.x1[EXP_MSB], ~s_q.x1[EXP_MSB],
					s_q.x1[EXP_MSB-1:EXP_LSB]};
				s_d.wait_storage_flop = 1'b0;
			end
			ST_03: s_d.u1 = s_q.u2;
			ST_05: s_d.x1[EXP_MSB:EXP_LSB] = '0;
			ST_06: s_d.x2 = s_q.sign_record_flop ? ~s_q.x1 : s_q.x1;
			ST_07: begin
				s_d.x1 = s_q.x2;
				s_d.sign_record_flop = 1'b0;
			end
			ST_08: begin
				s_d.u2 = diff;
				s_d.r2 = diff;
				s_d.keep_function_code_flop = 1'b1;
			end
			ST_09: begin
				s_d.x1 = '0;
				s_d.exp_diff_sign_flop = s_q.u2[EXP_W-1];
				s_d.partial_add_exp_flop = 1'b1;
			end
			ST_11: begin
				s_d.x1 = s_q.acc;
				if (s_q.exp_diff_sign_flop) begin
					s_d.u1 = '0;
					s_d.clear_acc_flop_b = 1'b1;
					s_d.acc = '0;
				end
			end
			ST_12: begin
				s_d.u2 = s_q.u1;
				s_d.keep_function_code_flop = 1'b0;
			end
			ST_13: begin
				s_d.clear_acc_flop_b = 1'b0;
				if (!s_q.exp_diff_sign_flop) begin
					s_d.x1 = s_q.x2;
				end
			end
			ST_14: begin
				// Larger exponent kept in U2
				if (s_q.exp_diff_sign_flop) begin
					s_d.u2 = s_q.u2 - s_q.r1;
				end
			end
			ST_15: begin
				if (s_q.exp_diff_sign_flop) begin
					s_d.acc = s_q.x2;
					s_d.r1 = ~s_q.r2 + CNT_ONE;
				end else begin
					s_d.r1 = s_q.r2;
				end
			end
			ST_16: begin
				s_d.r2 = s_q.r1;
				s_d.x2 = s_q.x1;
				s_d.zero_count_flop = 1'b1;
			end
			ST_17: begin
				s_d.zero_count_slave_a = 1'b1;
				s_d.zero_count_slave_b = 1'b1;
				s_d.partial_add_acc_flop = 1'b0;
			end
			ST_18: begin
				if (s_q.r1 == '0) begin
					s_d.zero_count_flop = 1'b0;
					s_d.zero_count_slave_a = 1'b0;
					s_d.zero_count_slave_b = 1'b0;
				end
			end
			ST_19: s_d.q = s_q.acc;
			ST_20: begin
				if (s_q.r1 >= SHIFT_LIMIT) begin
					s_d.clear_acc_flop = 1'b1;
					s_d.acc = '0;
				end
				if (s_q.r1 <= SHIFT_LIMIT) begin
					s_d.right_shift_enable_a = 1'b1;
					s_d.right_shift_enable_b = 1'b1;
				end
				s_d.float_shift_exit_flop = 1'b1;
			end
			ST_21: begin
				s_d.shift_exit_flop = 1'b1;
				// Too far out: go straight to round and normalize
				if (s_q.r1 > SHIFT_LIMIT) begin
					s_d.right_shift_enable_a = 1'b0;
					s_d.right_shift_enable_b = 1'b0;
				end else if (s_q.zero_count_flop) begin
					s_d.mode = FAS_ALIGN;
				end else begin
					s_d.right_shift_enable_a = 1'b0;
					s_d.right_shift_enable_b = 1'b0;
				end
			end
			ST_22: begin
				s_d.float_shift_exit_flop = 1'b0;
				s_d.shift_exit_flop = 1'b0;
				s_d.inhibit_acc_copy_flop = 1'b0;
				s_d.round_pending_flop =
					s_q.acc[SIGN_BIT] != s_q.q[SIGN_BIT];
			end
			ST_23: begin
				s_d.u1 = s_q.u2;
				s_d.clear_acc_flop = 1'b0;
			end
			ST_25: begin
				s_d.x1 = '0;
				s_d.acc = add_sum;
			end
			ST_26: begin
				s_d.force_unit_operand_flop = 1'b1;
				s_d.acc_negative_memo_flop = s_q.acc[SIGN_BIT];
				s_d.x2 = s_q.acc[SIGN_BIT] ? ~UNIT_WORD
					: UNIT_WORD;
				s_d.partial_add_exp_flop = 1'b0;
			end
			ST_28: begin
				s_d.force_unit_operand_flop = 1'b0;
				s_d.acc_negative_memo_flop = 1'b0;
			end
			ST_31: begin
				if (s_q.round_pending_flop) begin
					s_d.acc = add_sum;
				end
			end
			ST_33: begin
				s_d.x1 = '0;
				s_d.r1 = '0;
				s_d.left_normalize_flop = 1'b1;
			end
			ST_35: begin
				if (s_q.acc[NORM_HI] != s_q.acc[NORM_LO]) begin
					s_d.inhibit_acc_copy_flop = 1'b1;
					{s_d.acc, s_d.q} = {s_q.acc[SIGN_BIT],
						s_q.acc, s_q.q[WORD_W-1:1]};
					s_d.r1 = s_q.r1 - CNT_ONE;
					s_d.norm_right_memo = 1'b1;
				end else if (s_q.acc == '0 || s_q.acc == '1) begin
					// Minus zero too, else the left loop never ends
					s_d.left_normalize_flop = 1'b0;
				end else begin
					s_d.right_shift_exit_flop = 1'b1;
					s_d.mode = FAS_LNORM;
				end
			end
			ST_36: begin
				s_d.inhibit_acc_copy_flop = 1'b0;
				s_d.right_shift_exit_flop = 1'b0;
			end
			ST_39: begin
				// Only a right shift turns into a raise; left stays
				if (s_q.norm_right_memo) begin
					s_d.r1 = ~s_q.r1 + CNT_ONE;
				end
				s_d.norm_right_memo = 1'b0;
			end
			ST_41: begin
				s_d.x1 = s_q.acc;
				s_d.exp_diff_sign_flop = 1'b0;
				s_d.inhibit_add_flop = s_q.acc != '0 &&
					s_q.acc != '1;
				s_d.result_sign_flop = s_q.acc[SIGN_BIT];
				s_d.partial_add_acc_flop = 1'b1;
			end
			ST_42: s_d.x2 = s_q.result_sign_flop ? ~s_q.x1 : s_q.x1;
			ST_43: begin
				s_d.x1 = s_q.x2;
				s_d.clear_acc_flop = 1'b1;
				s_d.end_around_link_flop = 1'b0;
			end
			ST_44: begin
				if (s_q.inhibit_add_flop) begin
					s_d.u2 = exp_fin;
				end
			end
			ST_45: begin
				// Zero sum packs with no exponent and no bias
				s_d.x1[EXP_MSB:EXP_LSB] = s_q.inhibit_add_flop ?
					(s_q.u2[10:0] ^ EXP_BIAS) : '0;
				s_d.x1[SIGN_BIT] = 1'b0;
				s_d.ovf_pend = s_q.inhibit_add_flop &&
					$signed(s_q.u2) > $signed(EXP_MAX);
				s_d.unf_pend = s_q.inhibit_add_flop &&
					$signed(s_q.u2) < $signed(EXP_MIN);
				s_d.clear_acc_flop = 1'b0;
			end
			ST_46: begin
				s_d.x2 = s_q.result_sign_flop ? ~s_q.x1 : s_q.x1;
				s_d.result_sign_flop = 1'b0;
				s_d.inhibit_add_flop = 1'b0;
			end
			ST_47: begin
				s_d.acc = s_q.x2;
				if (s_q.unf_pend) begin
					s_d.acc = '0;
					s_d.underflow_clear_flop = 1'b1;
				end
				if (s_q.ovf_pend) begin
					s_d.overflow_fault_flop = 1'b1;
				end
			end
			ST_48: begin
				if (s_q.unf_pend) begin
					s_d.underflow_fault_flop = 1'b1;
				end
			end
			ST_49: begin
				s_d.underflow_clear_flop = 1'b0;
				s_d.ovf_pend = 1'b0;
				s_d.unf_pend = 1'b0;
				s_d.partial_add_acc_flop = 1'b0;
				s_d.mode = FAS_IDLE;
				s_d.done = 1'b1;
			end
			default: begin
				// Steps with no command just pass
			end
			endcase
		end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// All outputs straight from the state register, step_num from the chain step
	assign acc = s_q.acc;
	assign resid = s_q.q;
	assign busy = s_q.mode != FAS_IDLE;
	assign done = s_q.done;
	assign step_num = step;
	assign wait_storage = s_q.wait_storage_flop;
	assign round_pending = s_q.round_pending_flop;
	assign overflow_fault = s_q.overflow_fault_flop;
	assign underflow_fault = s_q.underflow_fault_flop;
endmodule

// >>> verif/fas_store_model.sv
// Storage model that hands the addend word to the sequencer
`timescale 1ns/1ns
module fas_store_model
	import fas_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              req,
	input  wire logic [WORD_W-1:0] word,
	output logic      [WORD_W-1:0] rd_data
);
	logic [WORD_W-1:0] last_q;

	// Released lines show the inverse, so stale data never looks valid
	assign rd_data = req ? word : ~last_q;

	// Remember the last word handed over
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			last_q <= '0;
		else if (req)
			last_q <= word;
	end
endmodule

// >>> verif/fas_seq_properties.sv
// Timing-chain properties of the floating add sequencer
`timescale 1ns/1ns
module fas_seq_props
	import fas_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic              start,
	input wire logic              fault_clear,
	input wire logic              busy,
	input wire logic              done,
	input wire logic [STEP_W-1:0] step_num,
	input wire logic              wait_storage,
	input wire logic              round_pending,
	input wire logic              overflow_fault,
	input wire logic              underflow_fault
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Start lands on sub-sequence step zero
	a_start_taken: assert property (
		start && !busy |=> busy && step_num == ST_00 && wait_storage)
		else $error("start not taken at step zero");
	a_step_advance: assert property (
		busy && step_num != ST_21 && step_num != ST_35 && step_num != ST_49
		|=> step_num == $past(step_num) + 6'h01)
		else $error("timing chain did not advance by one");
	a_wait_release: assert property (
		busy && step_num == ST_01 |-> wait_storage ##2 !wait_storage)
		else $error("wait storage not cleared after step two");
	a_align_exit: assert property (
		busy && step_num == ST_21 |-> ##[1:40] step_num == ST_22)
		else $error("alignment loop did not exit");
	a_left_resume: assert property (
		busy && step_num == ST_35 |=> step_num == ST_35 || step_num == ST_36)
		else $error("left normalize resumed at wrong step");
	a_done_once: assert property (
		busy && step_num == ST_49 |=> done && !busy ##1 !done)
		else $error("done pulse wrong after last step");
	a_round_step: assert property (
		$changed(round_pending) |-> $past(step_num) == ST_22)
		else $error("round flag moved outside step 22");
	a_ovf_step: assert property (
		$rose(overflow_fault) |-> $past(step_num) == ST_47)
		else $error("overflow fault set outside step 47");
	a_unf_step: assert property (
		$rose(underflow_fault) |-> $past(step_num) == ST_48)
		else $error("underflow fault set outside step 48");
	a_fault_clear: assert property (
		fault_clear && !busy |=> !overflow_fault && !underflow_fault)
		else $error("fault flags not cleared");
	a_run_length: assert property (
		start && !busy |-> ##[51:160] done)
		else $error("operation length out of range");

	// Main scenarios reached
	c_left_loop: cover property (step_num == ST_35 ##1 step_num == ST_35);
	c_round: cover property ($rose(round_pending));
	c_overflow: cover property ($rose(overflow_fault));
	c_underflow: cover property ($rose(underflow_fault));
endmodule

bind fas_seq fas_seq_props u_props (
	.clk(clk), .rst_b(rst_b), .start(start), .fault_clear(fault_clear),
	.busy(busy), .done(done), .step_num(step_num),
	.wait_storage(wait_storage), .round_pending(round_pending),
	.overflow_fault(overflow_fault), .underflow_fault(underflow_fault));

// >>> verif/tb_top.sv
// Self-checking bench for the floating add sequencer
`timescale 1ns/1ns
module tb_top
	import fas_pkg::*;
;
	logic              clk = 1'h0;
	logic              rst_b = 1'h0;
	logic              start = 1'h0;
	logic              fault_clear = 1'h0;
	logic [WORD_W-1:0] store_word = '0;
	logic [WORD_W-1:0] augend_char = '0;
	logic [EXP_W-1:0]  augend_exp_neg = '0;
	logic [WORD_W-1:0] addend;
	logic [WORD_W-1:0] acc;
	logic [WORD_W-1:0] resid;
	logic [STEP_W-1:0] step_num;
	logic              busy, done, wait_storage, round_pending, ovf, unf;
	int                errors = 0, checked = 0, seed = 36, tests = 0;

	// 50 MHz clock
	always #10 clk = ~clk;

	fas_store_model u_store (.clk(clk), .rst_b(rst_b), .req(start),
		.word(store_word), .rd_data(addend));
	fas_seq u_dut (.clk(clk), .rst_b(rst_b), .start(start),
		.addend(addend), .augend_char(augend_char),
		.augend_exp_neg(augend_exp_neg), .fault_clear(fault_clear),
		.acc(acc), .resid(resid), .busy(busy), .done(done),
		.step_num(step_num), .wait_storage(wait_storage),
		.round_pending(round_pending), .overflow_fault(ovf),
		.underflow_fault(unf));

	// Ones' complement add with end-around carry
	function automatic logic [47:0] oc(input logic [47:0] a, b);
		logic [48:0] t;
		t = {1'h0, a} + {1'h0, b};
		return t[47:0] + {47'h0, t[48]};
	endfunction

	task automatic chk(input string nm, input logic [47:0] ex, got);
		checked++;
		if (got !== ex) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// One add: model the result, run the design, compare
	task automatic run_case(input bit sa, input logic [35:0] ca,
		input int ea, input bit sb, input logic [35:0] cb, input int eb);
		logic [47:0] xa, xb, big, sm, s, r, w, q;
		logic [95:0] aq;
		int n, e, k;
		bit rnd, ov, un;
		xa = {12'h000, ca};
		if (sa) xa = ~xa;
		xb = {12'h000, cb};
		if (sb) xb = ~xb;
		w = {1'h0, 11'(eb + 1024), cb};
		if (sb) w = ~w;
		// Smaller exponent gets aligned, larger keeps its characteristic
		if (eb < ea) begin
			big = xa; sm = xb; n = ea - eb; e = ea;
		end else begin
			big = xb; sm = xa; n = eb - ea; e = eb;
		end
		// Aligned operand and residue shift as one double word
		aq = {(n >= 36) ? 48'h0 : sm, sm};
		if (n <= 36) aq = $signed(aq) >>> n;
		rnd = aq[95] != aq[47];
		s = oc(big, aq[95:48]);
		q = aq[47:0];
		if (rnd) s = oc(s, s[47] ? ~UNIT_WORD : UNIT_WORD);
		// Guard against minus zero, which has no normal form
		if (s[37] != s[36]) begin
			{s, q} = $signed({s, q}) >>> 1;
			e++;
		end else if (s != 48'h0 && ~s != 48'h0)
			while (s[35] == s[47]) begin
				{s, q} = {s[46:0], q, s[47]};
				e--;
			end
		ov = e > 1023;
		un = e < -1024;
		r = {1'h0, 11'(e + 1024), s[47] ? ~s[35:0] : s[35:0]};
		if (s[47]) r = ~r;
		// A zero sum of either sign passes through unbiased
		if (s == 48'h0 || ~s == 48'h0) r = s;
		else if (un) r = 48'h0;
		@(posedge clk);
		fault_clear <= 1'h1;
		store_word <= w;
		augend_char <= xa;
		augend_exp_neg <= 12'(-ea);
		@(posedge clk);
		fault_clear <= 1'h0;
		start <= 1'h1;
		@(posedge clk);
		start <= 1'h0;
		store_word <= ~w;
		augend_char <= ~xa;
		repeat (4) @(posedge clk);
		start <= 1'h1;
		@(posedge clk);
		start <= 1'h0;
		k = 0;
		while (done !== 1'h1 && k < 300) begin
			@(negedge clk);
			k++;
		end
		if (k >= 300) errors++;
		if (!ov) chk("acc", r, acc);
		chk("resid", q, resid);
		chk("overflow", {47'h0, ov}, {47'h0, ovf});
		chk("underflow", {47'h0, un}, {47'h0, unf});
		chk("round", {47'h0, rnd}, {47'h0, round_pending});
		tests++;
		$display("test %0d finished", tests);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence, refused second start inside every case
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'h1;
		run_case(0, 36'h8_0000_0000, 5, 0, 36'h8_0000_0000, 5);
		run_case(0, 36'hC_0000_0001, 10, 1, 36'h8_0000_0007, 7);
		run_case(0, 36'h9_0000_0000, 50, 1, 36'hA_0000_0000, 0);
		run_case(1, 36'hF_0000_0000, -3, 0, 36'h8_0000_0001, 33);
		run_case(0, 36'h8_0000_0003, 2, 1, 36'h8_0000_0001, 2);
		run_case(0, 36'h8_0000_0000, 1023, 0, 36'h8_0000_0000, 1023);
		run_case(0, 36'h8_0000_0003, -1024, 1, 36'h8_0000_0001, -1024);
		repeat (8) begin
			run_case(1'($random(seed)), {4'h8, 32'($random(seed))},
				$random(seed) % 20, 1'($random(seed)),
				{4'h8, 32'($random(seed))}, $random(seed) % 20);
		end
		complete_run;
	end

	// Cut a hang short
	initial begin
		#400000;
		errors++;
		$display("watchdog expired");
		complete_run;
	end
endmodule
